// *** core/lookup_pkg.sv ***
// ************************************************
// shared constants for the lookup search block
// ************************************************
package lookup_pkg;
  // dio byte addresses of the search interface
  localparam logic [7:0] ADDR_VLAN_LO = 8'h0a; // search vlan, low byte
  localparam logic [7:0] ADDR_VLAN_HI = 8'h0b; // search vlan, high nibble
  localparam logic [7:0] ADDR_NODE_LO = 8'h0c; // result node, least byte
  localparam logic [7:0] ADDR_NODE_HI = 8'h11; // result node, most byte
  localparam logic [7:0] ADDR_PORT_LO = 8'h12; // result port, reserved byte
  localparam logic [7:0] ADDR_PORT_HI = 8'h13; // result port, tag and code
  localparam logic [7:0] ADDR_CTRL = 8'h16; // search command
  // dio byte addresses of the statistics
  localparam logic [7:0] ADDR_SEC = 8'h17; // security violations
  localparam logic [7:0] ADDR_UNI_LO = 8'h18; // unknown unicast low
  localparam logic [7:0] ADDR_UNI_HI = 8'h19; // unknown unicast high
  localparam logic [7:0] ADDR_MUL_LO = 8'h1a; // unknown multicast low
  localparam logic [7:0] ADDR_MUL_HI = 8'h1b; // unknown multicast high
  localparam logic [7:0] ADDR_CNT_LO = 8'h1c; // entry count low
  localparam logic [7:0] ADDR_CNT_HI = 8'h1d; // entry count high
  // search command bit positions
  localparam int BIT_FOUND = 7; // result valid
  localparam int BIT_NEW = 6; // newly learned search
  localparam int BIT_NONBLOCKED_FIFO_READ = 5; // nonblocked fifo read
  localparam int BIT_PORT = 4; // port qualifier
  localparam int BIT_VLAN = 3; // vlan qualifier
  localparam int BIT_FIRST = 2; // first entry
  localparam int BIT_NEXT = 1; // next entry
  localparam int BIT_EXACT_LOOKUP = 0; // exact lookup
  localparam logic [7:0] CMD_MASK = 8'h67; // all command bits
  localparam logic [7:0] CTRL_RESET = 8'h00; // command reset value
  // table and field shapes
  localparam int TBL_AW = 11; // 2k entries
  localparam logic [TBL_AW-1:0] IDX_ZERO = 11'h000; // table start
  localparam logic [TBL_AW-1:0] IDX_LAST = 11'h7ff; // table end
  localparam logic [TBL_AW-1:0] IDX_ONE = 11'h001; // scan step
  localparam int MAC_W = 48; // address width
  localparam int VLAN_W = 12; // vlan id width
  localparam int PORT_W = 4; // port code width
  localparam int MCAST_BIT = 40; // group address bit
  localparam int SEC_W = 8; // security counter width
  localparam int CNT_W = 16; // wide counter width
  // search engine states
  typedef enum logic [2:0] {S_IDLE, S_READ, S_EVAL, S_FIFO, S_DONE} search_state_e;
endpackage

// *** core/stat_if.sv ***
`timescale 1ns/10ps
// ************************************************
// events and read port of the statistics bank
// ************************************************
interface stat_if;
  import lookup_pkg::*;
  logic sec_event; // secured address moved
  logic uni_event; // unknown unicast flooded
  logic mul_event; // unknown multicast flooded
  logic add_event; // entry stored
  logic del_event; // entry removed
  logic rd_strobe; // host read this cycle
  logic [7:0] rd_addr; // host read address
  logic [7:0] rd_data; // bank read value
  logic stat_pulse; // a counter msb rose
  modport bank (input sec_event, uni_event, mul_event, add_event, del_event,
    rd_strobe, rd_addr, output rd_data, stat_pulse);
  modport ctrl (output sec_event, uni_event, mul_event, add_event, del_event,
    rd_strobe, rd_addr, input rd_data, stat_pulse);
endinterface // stat_if

// *** core/entry_match.sv ***
`timescale 1ns/10ps
// ************************************************
// decides whether a table entry satisfies a search
// ************************************************
module entry_match
  import lookup_pkg::*;
(
  input wire logic [7:0] cmd_i, // command and qualifiers
  input wire logic valid_i, // entry holds an address
  input wire logic new_i, // entry newly learned
  input wire logic [MAC_W-1:0] mac_i, // entry address
  input wire logic [VLAN_W-1:0] vlan_i, // entry vlan
  input wire logic [PORT_W-1:0] port_i, // entry port
  input wire logic [MAC_W-1:0] node_i, // result node value
  input wire logic [VLAN_W-1:0] svlan_i, // search vlan value
  input wire logic [PORT_W-1:0] scode_i, // search port code
  input wire logic passed_i, // current node already seen
  output logic same_o, // entry equals result node
  output logic hit_o // entry is the answer
);
  logic qual; // qualifiers satisfied
  // qualifiers and command criteria
  always_comb begin
    same_o = valid_i && (mac_i == node_i);
    qual = 1'b1;
    if (cmd_i[BIT_PORT]) begin
      qual = qual && !mac_i[MCAST_BIT] && (port_i == scode_i);
    end
    if (cmd_i[BIT_VLAN]) begin
      qual = qual && (vlan_i == svlan_i);
    end
    hit_o = 1'b0;
    if (cmd_i[BIT_FIRST]) begin
      hit_o = valid_i && qual;
    end
    if (cmd_i[BIT_NEW]) begin
      hit_o = valid_i && new_i && qual;
    end
    if (cmd_i[BIT_NEXT]) begin
      hit_o = passed_i && valid_i && qual;
    end
    if (cmd_i[BIT_EXACT_LOOKUP]) begin
      hit_o = same_o && qual;
    end
  end
endmodule // entry_match

// *** core/stat_bank.sv ***
`timescale 1ns/10ps
// ************************************************
// statistics counters with shared high byte latch
// ************************************************
module stat_bank
  import lookup_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic rst_i, // sync reset
  stat_if.bank st // events and reads
);
  logic [SEC_W-1:0] sec_reg; // security violations
  logic [CNT_W-1:0] nodes_reg; // entries in table
  logic [7:0] hold_reg; // shared high byte
  logic [2:0] msb_prev_reg; // last msb values
  logic [2:0] msb_now; // current msb values
  logic [1:0] fl_ev; // flood events
  logic [1:0] fl_rd; // flood low byte reads
  logic [CNT_W-1:0] fl_val [2]; // flood counts
  logic rd_sec; // security counter read
  assign rd_sec = st.rd_strobe && (st.rd_addr == ADDR_SEC);
  assign fl_ev = {st.mul_event, st.uni_event};
  assign fl_rd[0] = st.rd_strobe && (st.rd_addr == ADDR_UNI_LO);
  assign fl_rd[1] = st.rd_strobe && (st.rd_addr == ADDR_MUL_LO);
  // flood counters, one per traffic class
  for (genvar g = 0; g < 2; g++) begin : g_flood
    logic [CNT_W-1:0] cnt_reg; // flood count
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cnt_reg <= '0;
      end else if (fl_ev[g]) begin
        cnt_reg <= fl_rd[g] ? CNT_W'(1) : cnt_reg + CNT_W'(1);
      end else if (fl_rd[g]) begin
        cnt_reg <= '0;
      end
    end
    assign fl_val[g] = cnt_reg;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sec_reg <= '0;
    end else if (st.sec_event) begin
      sec_reg <= rd_sec ? SEC_W'(1) : sec_reg + SEC_W'(1);
    end else if (rd_sec) begin
      sec_reg <= '0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nodes_reg <= '0;
    end else if (st.add_event && !st.del_event) begin
      nodes_reg <= nodes_reg + CNT_W'(1);
    end else if (st.del_event && !st.add_event) begin
      nodes_reg <= nodes_reg - CNT_W'(1);
    end
  end
  // latch high byte on low read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_reg <= '0;
    end else if (fl_rd[0]) begin
      hold_reg <= fl_val[0][15:8];
    end else if (fl_rd[1]) begin
      hold_reg <= fl_val[1][15:8];
    end else if (st.rd_strobe && (st.rd_addr == ADDR_CNT_LO)) begin
      hold_reg <= nodes_reg[15:8];
    end
  end
  assign msb_now = {sec_reg[SEC_W-1], fl_val[1][CNT_W-1], fl_val[0][CNT_W-1]};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      msb_prev_reg <= '0;
    end else begin
      msb_prev_reg <= msb_now;
    end
  end
  assign st.stat_pulse = |(msb_now & ~msb_prev_reg);
  always_comb begin
    case (st.rd_addr)
      ADDR_SEC: st.rd_data = sec_reg;
      ADDR_UNI_LO: st.rd_data = fl_val[0][7:0];
      ADDR_MUL_LO: st.rd_data = fl_val[1][7:0];
      ADDR_CNT_LO: st.rd_data = nodes_reg[7:0];
      ADDR_UNI_HI, ADDR_MUL_HI, ADDR_CNT_HI: st.rd_data = hold_reg;
      default: st.rd_data = 8'h00;
    endcase
  end
  // ************************************************
  // checks
  // ************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sec_clear_a:
    assert property (rd_sec && !st.sec_event |=> sec_reg == 8'h00)
    else $error("security counter not cleared by read");
  hold_copy_a:
    assert property (fl_rd[0] |=> hold_reg == $past(fl_val[0][15:8]))
    else $error("high byte not latched");
  flood_inc_a:
    assert property (st.uni_event && !fl_rd[0] |=> fl_val[0] == $past(fl_val[0]) + 16'h0001)
    else $error("unicast flood not counted");
endmodule // stat_bank

// *** core/lookup_search_and_stats.sv ***
`timescale 1ns/10ps
module lookup_search_and_stats
  import lookup_pkg::*;
(
  input wire logic MCLK_I, // 200 mhz clock
  input wire logic RESET_I, // sync reset, high
  input wire logic [7:0] DIO_ADDR_I, // register byte address
  input wire logic [7:0] DIO_WDATA_I, // write byte
  input wire logic DIO_WR_I, // write strobe
  input wire logic DIO_RD_I, // read strobe
  output logic [7:0] DIO_RDATA_O, // read byte
  output logic DIO_RVALID_O, // read byte valid
  output logic TBL_RD_O, // table read request
  output logic [TBL_AW-1:0] TBL_IDX_O, // table index
  output logic TBL_CLR_NEW_O, // clear new marker at index
  input wire logic TBL_VALID_I, // entry holds an address
  input wire logic TBL_NEW_I, // entry newly learned
  input wire logic [MAC_W-1:0] TBL_MAC_I, // entry address
  input wire logic [VLAN_W-1:0] TBL_VLAN_I, // entry vlan
  input wire logic [PORT_W-1:0] TBL_PORT_I, // entry port code
  input wire logic NBF_VALID_I, // nonblocked fifo not empty
  input wire logic [MAC_W-1:0] NBF_MAC_I, // fifo head address
  input wire logic [PORT_W-1:0] NBF_PORT_I, // fifo head port
  input wire logic [PORT_W-1:0] NBF_TAG_I, // fifo head tag
  output logic NBF_POP_O, // fifo head taken
  output logic NBF_PENDING_O, // fifo holds an entry
  input wire logic SEC_VIO_I, // secured address moved
  input wire logic UNK_UCAST_I, // unicast flooded
  input wire logic UNK_MCAST_I, // multicast flooded
  input wire logic NODE_ADD_I, // entry stored
  input wire logic NODE_DEL_I, // entry removed
  output logic SEARCH_DONE_O, // search complete pulse
  output logic STAT_IRQ_O // statistics half full pulse
);
  // ************************************************
  // state
  // ************************************************
  search_state_e state_reg; // engine state
  logic [7:0] ctrl_reg; // search command register
  logic [MAC_W-1:0] node_reg; // result node
  logic [VLAN_W-1:0] vlan_reg; // search and result vlan
  logic [PORT_W-1:0] pcode_reg; // result port code
  logic [PORT_W-1:0] tag_reg; // result frame tag
  logic [TBL_AW-1:0] idx_reg; // scan index
  logic passed_reg; // next scan passed current node
  logic tbl_rd_reg; // table read request
  logic clr_new_reg; // new marker clear
  logic pop_reg; // fifo pop
  logic done_reg; // completion pulse
  logic pend_reg; // fifo pending
  logic stat_reg; // statistics pulse
  logic [7:0] rdata_reg; // read byte
  logic rvalid_reg; // read valid
  logic [7:0] rd_mux; // selected read byte
  logic [7:0] cmd_w; // command bits written
  logic [7:0] node_off; // node byte offset
  logic wr_ctrl; // write to command register
  logic onehot; // at most one command
  logic idle; // engine idle
  logic start; // launch a command
  logic node_sel; // address in node range
  logic hit; // entry answers search
  logic same; // entry equals node
  stat_if st (); // statistics link
  // ************************************************
  // decode
  // ************************************************
  assign idle = (state_reg == S_IDLE);
  assign wr_ctrl = DIO_WR_I && (DIO_ADDR_I == ADDR_CTRL);
  assign cmd_w = DIO_WDATA_I & CMD_MASK;
  assign onehot = ((cmd_w & (cmd_w - 8'h01)) == 8'h00);
  assign start = wr_ctrl && idle && onehot && (cmd_w != 8'h00);
  assign node_off = DIO_ADDR_I - ADDR_NODE_LO;
  assign node_sel = (DIO_ADDR_I >= ADDR_NODE_LO) && (DIO_ADDR_I <= ADDR_NODE_HI);
  // entry qualification
  entry_match u_match (
    .cmd_i(ctrl_reg),
    .valid_i(TBL_VALID_I),
    .new_i(TBL_NEW_I),
    .mac_i(TBL_MAC_I),
    .vlan_i(TBL_VLAN_I),
    .port_i(TBL_PORT_I),
    .node_i(node_reg),
    .svlan_i(vlan_reg),
    .scode_i(pcode_reg),
    .passed_i(passed_reg),
    .same_o(same),
    .hit_o(hit)
  );
  // statistics bank
  assign st.sec_event = SEC_VIO_I;
  assign st.uni_event = UNK_UCAST_I;
  assign st.mul_event = UNK_MCAST_I;
  assign st.add_event = NODE_ADD_I;
  assign st.del_event = NODE_DEL_I;
  assign st.rd_strobe = DIO_RD_I;
  assign st.rd_addr = DIO_ADDR_I;
  stat_bank u_stats (
    .clk_i(MCLK_I),
    .rst_i(RESET_I),
    .st(st)
  );
  // ************************************************
  // search engine
  // ************************************************
  // scan sequencing
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      state_reg <= S_IDLE;
      idx_reg <= IDX_ZERO;
      passed_reg <= 1'b0;
      tbl_rd_reg <= 1'b0;
    end else begin
      tbl_rd_reg <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (start && cmd_w[BIT_NONBLOCKED_FIFO_READ]) begin
            state_reg <= S_FIFO;
          end else if (start) begin
            idx_reg <= IDX_ZERO;
            passed_reg <= 1'b0;
            tbl_rd_reg <= 1'b1;
            state_reg <= S_READ;
          end
        end
        S_READ: state_reg <= S_EVAL; // entry arrives next
        S_EVAL: begin
          if (hit || (idx_reg == IDX_LAST)) begin
            state_reg <= S_DONE;
          end else begin
            passed_reg <= passed_reg || same;
            idx_reg <= idx_reg + IDX_ONE;
            tbl_rd_reg <= 1'b1;
            state_reg <= S_READ;
          end
        end
        S_FIFO: state_reg <= S_DONE; // head sampled
        S_DONE: state_reg <= S_IDLE;
        default: state_reg <= S_IDLE;
      endcase
    end
  end
  // command register and found flag
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      ctrl_reg <= CTRL_RESET;
    end else if (idle && wr_ctrl && onehot) begin
      ctrl_reg <= {ctrl_reg[BIT_FOUND], DIO_WDATA_I[6:0]};
    end else if (state_reg == S_EVAL && hit) begin
      ctrl_reg[BIT_FOUND] <= 1'b1;
    end else if (state_reg == S_EVAL && idx_reg == IDX_LAST) begin
      ctrl_reg[BIT_FOUND] <= 1'b0;
    end else if (state_reg == S_FIFO) begin
      ctrl_reg[BIT_FOUND] <= NBF_VALID_I;
    end else if (state_reg == S_DONE) begin
      ctrl_reg <= ctrl_reg & ~CMD_MASK;
    end
  end
  // result registers
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      node_reg <= '0;
      vlan_reg <= '0;
      pcode_reg <= '0;
      tag_reg <= '0;
    end else if (state_reg == S_EVAL && hit) begin
      node_reg <= TBL_MAC_I;
      vlan_reg <= TBL_VLAN_I;
      pcode_reg <= TBL_PORT_I;
    end else if (state_reg == S_FIFO && NBF_VALID_I) begin
      node_reg <= NBF_MAC_I;
      pcode_reg <= NBF_PORT_I;
      tag_reg <= NBF_TAG_I;
    end else if (DIO_WR_I && idle) begin
      if (node_sel) begin
        node_reg[8*node_off[2:0] +: 8] <= DIO_WDATA_I;
      end
      if (DIO_ADDR_I == ADDR_VLAN_LO) begin
        vlan_reg[7:0] <= DIO_WDATA_I;
      end
      if (DIO_ADDR_I == ADDR_VLAN_HI) begin
        vlan_reg[VLAN_W-1:8] <= DIO_WDATA_I[3:0];
      end
      if (DIO_ADDR_I == ADDR_PORT_HI) begin
        pcode_reg <= DIO_WDATA_I[3:0];
        tag_reg <= DIO_WDATA_I[7:4];
      end
    end
  end
  // side effect pulses and fifo pending flag
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      clr_new_reg <= 1'b0;
      pop_reg <= 1'b0;
      done_reg <= 1'b0;
      pend_reg <= 1'b0;
      stat_reg <= 1'b0;
    end else begin
      clr_new_reg <= (state_reg == S_EVAL) && hit && ctrl_reg[BIT_NEW];
      pop_reg <= (state_reg == S_FIFO) && NBF_VALID_I;
      done_reg <= (state_reg == S_DONE);
      pend_reg <= NBF_VALID_I;
      stat_reg <= st.stat_pulse;
    end
  end
  // ************************************************
  // register reads
  // ************************************************
  // local read mux, bank for the rest
  always_comb begin
    if (node_sel) begin
      rd_mux = node_reg[8*node_off[2:0] +: 8];
    end else begin
      case (DIO_ADDR_I)
        ADDR_CTRL: rd_mux = ctrl_reg;
        ADDR_VLAN_LO: rd_mux = vlan_reg[7:0];
        ADDR_VLAN_HI: rd_mux = {4'h0, vlan_reg[VLAN_W-1:8]};
        ADDR_PORT_HI: rd_mux = {tag_reg, pcode_reg};
        default: rd_mux = st.rd_data;
      endcase
    end
  end
  // registered read answer
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= DIO_RD_I;
      if (DIO_RD_I) begin
        rdata_reg <= rd_mux;
      end
    end
  end
  assign DIO_RDATA_O = rdata_reg;
  assign DIO_RVALID_O = rvalid_reg;
  assign TBL_RD_O = tbl_rd_reg;
  assign TBL_IDX_O = idx_reg;
  assign TBL_CLR_NEW_O = clr_new_reg;
  assign NBF_POP_O = pop_reg;
  assign NBF_PENDING_O = pend_reg;
  assign SEARCH_DONE_O = done_reg;
  assign STAT_IRQ_O = stat_reg;
  // ************************************************
  // checks
  // ************************************************
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);
  sequence s_fifo_start;
    idle && start && cmd_w[BIT_NONBLOCKED_FIFO_READ];
  endsequence
  sequence s_fifo_run;
    ctrl_reg[BIT_NONBLOCKED_FIFO_READ] ##1 ctrl_reg[BIT_NONBLOCKED_FIFO_READ] ##1 !ctrl_reg[BIT_NONBLOCKED_FIFO_READ];
  endsequence
  found_ro_a:
    assert property (idle && wr_ctrl |=> ctrl_reg[BIT_FOUND] == $past(ctrl_reg[BIT_FOUND]))
    else $error("found bit changed by host write");
  new_clear_a:
    assert property (state_reg == S_EVAL && hit && ctrl_reg[BIT_NEW]
      |=> TBL_CLR_NEW_O && TBL_IDX_O == $past(idx_reg))
    else $error("new marker not cleared");
  scan_start_a:
    assert property (start && cmd_w[BIT_NEW] |=> TBL_RD_O && TBL_IDX_O == IDX_ZERO)
    else $error("new search not at table start");
  fifo_found_a:
    assert property (state_reg == S_FIFO
      |=> ctrl_reg[BIT_FOUND] == $past(NBF_VALID_I) && NBF_POP_O == $past(NBF_VALID_I))
    else $error("fifo read result wrong");
  fifo_held_a:
    assert property (s_fifo_start |=> s_fifo_run)
    else $error("fifo read bit not held to end");
  port_qual_a:
    assert property (state_reg == S_EVAL && hit && ctrl_reg[BIT_PORT]
      |-> !TBL_MAC_I[MCAST_BIT] && TBL_PORT_I == pcode_reg)
    else $error("port qualifier not honoured");
  ctrl_lock_a:
    assert property ((state_reg == S_READ || state_reg == S_EVAL) && wr_ctrl
      |=> ctrl_reg[6:0] == $past(ctrl_reg[6:0]))
    else $error("command register written while busy");
  done_clear_a:
    assert property (state_reg == S_DONE |=> (ctrl_reg & CMD_MASK) == 8'h00 && SEARCH_DONE_O)
    else $error("completion did not clear command");
  multi_ign_a:
    assert property (idle && wr_ctrl && !onehot
      |=> state_reg == S_IDLE && ctrl_reg == $past(ctrl_reg))
    else $error("multiple command write accepted");
endmodule // lookup_search_and_stats

// *** tb/table_model.sv ***
`timescale 1ns/10ps
// ************************************************
// small lookup table answering the scan port
// ************************************************
module table_model
  import lookup_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic rd_i, // read request
  input wire logic [TBL_AW-1:0] idx_i, // entry index
  input wire logic clr_i, // clear new marker
  output logic valid_o, // entry holds an address
  output logic new_o, // newly learned
  output logic [MAC_W-1:0] mac_o, // entry address
  output logic [VLAN_W-1:0] vlan_o, // entry vlan
  output logic [PORT_W-1:0] port_o // entry port
);
  logic [3:0] nw_reg = 4'b0100; // only entry two starts new
  logic lo; // index inside populated part
  assign lo = idx_i < 4;
  // answer one cycle after a read, scramble otherwise
  always_ff @(posedge clk_i) begin
    if (clr_i && lo) nw_reg[idx_i[1:0]] <= 1'b0;
    if (rd_i) begin
      valid_o <= lo && idx_i != 0;
      new_o <= lo && nw_reg[idx_i[1:0]];
      mac_o <= {7'h00, idx_i == 11'h002, 29'h0, idx_i};
      vlan_o <= (idx_i == 11'h001) ? 12'h005 : 12'h007;
      port_o <= (idx_i == 11'h001) ? 4'h2 : 4'h3;
    end else begin
      valid_o <= ~valid_o;
      new_o <= ~new_o;
      mac_o <= ~mac_o;
    end
  end
endmodule // table_model

// *** tb/test_lookup_search_and_stats.sv ***
`timescale 1ns/10ps
module test_lookup_search_and_stats;
  import lookup_pkg::*;
  typedef struct {logic [7:0] c; logic [47:0] n; logic f; logic [47:0] o;} row_s;
  logic clk = 0, rst = 1, wr = 0, rd = 0, nv = 0;
  logic [7:0] ad = 8'h00, wd = 8'h00, rdat, v;
  logic [4:0] ev = 5'h00; // event pulses
  logic rv, trd, tclr, tv, tn, done, pop, pend, irq;
  logic [TBL_AW-1:0] tix;
  logic [47:0] tm, nd;
  logic [11:0] tvl;
  logic [3:0] tp;
  int bad_count = 0, tests_run = 0, irqs = 0, pops = 0, i;
  row_s rows [8] = '{'{8'h04, 48'h0, 1, 48'h1}, '{8'h02, 48'h1, 1, 48'h010000000002},
    '{8'h01, 48'h3, 1, 48'h3}, '{8'h01, 48'h99, 0, 48'h0}, '{8'h40, 48'h0, 1, 48'h010000000002},
    '{8'h40, 48'h0, 0, 48'h0}, '{8'h0c, 48'h0, 1, 48'h010000000002}, '{8'h14, 48'h0, 1, 48'h3}};
  logic [7:0] z [4] = '{ADDR_SEC, ADDR_UNI_LO, ADDR_MUL_LO, ADDR_CNT_LO};
  initial forever #2.5 clk = ~clk;
  // count one-cycle pulses of the irq and fifo pop outputs
  always @(posedge clk) begin
    if (irq === 1'b1) irqs++;
    if (pop === 1'b1) pops++;
  end
  lookup_search_and_stats dut_u (.MCLK_I(clk), .RESET_I(rst), .DIO_ADDR_I(ad), .DIO_WDATA_I(wd),
    .DIO_WR_I(wr), .DIO_RD_I(rd), .DIO_RDATA_O(rdat), .DIO_RVALID_O(rv), .TBL_RD_O(trd),
    .TBL_IDX_O(tix), .TBL_CLR_NEW_O(tclr), .TBL_VALID_I(tv), .TBL_NEW_I(tn), .TBL_MAC_I(tm),
    .TBL_VLAN_I(tvl), .TBL_PORT_I(tp), .NBF_VALID_I(nv), .NBF_MAC_I(48'h222200000005),
    .NBF_PORT_I(4'h6), .NBF_TAG_I(4'h9), .NBF_POP_O(pop), .NBF_PENDING_O(pend),
    .SEC_VIO_I(ev[0]), .UNK_UCAST_I(ev[1]), .UNK_MCAST_I(ev[2]), .NODE_ADD_I(ev[3]),
    .NODE_DEL_I(ev[4]), .SEARCH_DONE_O(done), .STAT_IRQ_O(irq));
  table_model tm_u (.clk_i(clk), .rd_i(trd), .idx_i(tix), .clr_i(tclr), .valid_o(tv),
    .new_o(tn), .mac_o(tm), .vlan_o(tvl), .port_o(tp));
  // ************************************************
  // checking and bus tasks
  // ************************************************
  task automatic chk(string s, logic [47:0] g, logic [47:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic w(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    ad <= a; wd <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic r(logic [7:0] a);
    @(posedge clk);
    ad <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rvalid", rv, 1);
    v = rdat;
  endtask
  task automatic wn(logic [47:0] n);
    for (int k = 0; k < 6; k++) w(8'(12 + k), n[8*k+:8]);
  endtask
  task automatic rn;
    for (int k = 0; k < 6; k++) begin r(8'(12 + k)); nd[8*k+:8] = v; end
  endtask
  task automatic wt; // bounded wait for completion
    for (i = 0; i < 9000 && done !== 1'b1; i++) @(posedge clk) #1;
    if (i == 9000) begin
      chk("timeout", i, 0);
      end_sim;
    end
  endtask
  task automatic pe(int b, int n);
    repeat (n) begin @(posedge clk); ev <= 5'(1 << b); @(posedge clk); ev <= 5'h00; end
  endtask
  // ************************************************
  // main sequence
  // ************************************************
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    foreach (z[k]) begin r(z[k]); chk("rstval", v, 0); end
    w(ADDR_VLAN_LO, 8'h07);
    w(ADDR_PORT_HI, 8'h03);
    foreach (rows[k]) begin
      wn(rows[k].n); w(ADDR_CTRL, rows[k].c); wt; r(ADDR_CTRL);
      chk("ctrl", {v[7], v & CMD_MASK}, {rows[k].f, 8'h00});
      if (rows[k].f) begin rn; chk("node", nd, rows[k].o); end
    end
    wn(48'h99); w(ADDR_CTRL, 8'h01); w(ADDR_CTRL, 8'h04); r(ADDR_CTRL);
    chk("lock", v & CMD_MASK, 8'h01);
    wt;
    w(ADDR_CTRL, 8'h06); r(ADDR_CTRL); chk("multi", v & CMD_MASK, 0);
    @(posedge clk) nv <= 1'b1;
    @(posedge clk) #1 chk("pend", pend, 1);
    w(ADDR_CTRL, 8'h20); wt; r(ADDR_CTRL); chk("ffound", v[7], 1);
    rn; chk("fnode", nd, 48'h222200000005);
    r(ADDR_PORT_HI); chk("fport", v, 8'h96);
    @(posedge clk) nv <= 1'b0;
    w(ADDR_CTRL, 8'h20); wt; r(ADDR_CTRL); chk("fempty", v[7], 0);
    chk("pops", pops, 1);
    pe(0, 3); r(ADDR_SEC); chk("sec", v, 3); r(ADDR_SEC); chk("secclr", v, 0);
    pe(1, 258); r(ADDR_UNI_LO); chk("uni", v, 2);
    r(ADDR_UNI_HI); chk("unih", v, 1); r(ADDR_UNI_LO); chk("uniclr", v, 0);
    pe(2, 1); r(ADDR_MUL_LO); chk("mul", v, 1); r(ADDR_MUL_HI); chk("mulh", v, 0);
    pe(3, 3); pe(4, 1); r(ADDR_CNT_LO); chk("cnt", v, 2);
    r(ADDR_CNT_LO); chk("cntkeep", v, 2);
    chk("irq0", irqs, 0); pe(0, 128); repeat (3) @(posedge clk);
    chk("irq", irqs, 1);
    rst <= 1'b1; repeat (2) @(posedge clk); rst <= 1'b0;
    foreach (z[k]) begin r(z[k]); chk("rst2", v, 0); end
    end_sim;
  end
endmodule // test_lookup_search_and_stats
